// ---- core/flash_sec_cfg.svh ----
// Constants of the security register and read parameter engine.
// Holds definitions only; included by bare name where needed.
`ifndef FLASH_SEC_CFG_SVH
`define FLASH_SEC_CFG_SVH
`define OP_SEC_ERASE   8'h44
`define OP_SEC_PROG    8'h42
`define OP_SEC_READ    8'h48
`define OP_SET_PARAM   8'hC0
`define OP_FAST_READ   8'h0B
`define OP_QIO_READ    8'hEB
`define OP_WRAP_READ   8'h0C
`define OP_ENTER_QUAD  8'h38
`define OP_EXIT_QUAD   8'hFF
`define OP_NONE        8'h00
`define SEC_SEL_FIRST  4'h1
`define SEC_SEL_LAST   4'h3
`define SEC_DUMMY_CLKS 6'h08
`define ADDR_BITS_3B   6'h18
`define ADDR_BITS_4B   6'h20
`define DUMMY_SEL_RST  2'h0
`define WRAP_SEL_RST   2'h0
`define WRAP_BASE_LEN  7'h08
`define DUMMY_BASE     4'h2
`define CLK_MHZ        40
`define SEC_ERASE_US   100
`define SEC_PROG_US    20
`define FIFO_DEPTH     32
`define SEC_ENTRIES    768
`endif

// ---- core/flash_sec_pkg.sv ----
// Types shared by the security register engine and its helpers.
// Assumes nothing beyond a SystemVerilog package scope.
package flash_sec_pkg;
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_SKIP
  } frame_t;
endpackage

// ---- core/store_if.sv ----
// Carrier between the engine, its byte store and its read FIFO.
// Assumes all parties run on the engine clock.
`timescale 1ns/1ps
`default_nettype none
interface store_if #(parameter int unsigned DW = 8) ();
  logic          wr_en;
  logic          wr_erase;
  logic [9:0]    wr_idx;
  logic [7:0]    wr_data;
  logic          rd_en;
  logic [9:0]    rd_idx;
  logic [7:0]    rd_data;
  logic          f_flush;
  logic          f_in_valid;
  logic          f_in_ready;
  logic [DW-1:0] f_in_data;
  logic          f_out_valid;
  logic          f_out_ready;
  logic [DW-1:0] f_out_data;
  modport mem (input wr_en, wr_erase, wr_idx, wr_data, rd_en, rd_idx,
               output rd_data);
  modport fifo (input f_flush, f_in_valid, f_in_data, f_out_ready,
                output f_in_ready, f_out_valid, f_out_data);
endinterface
`default_nettype wire

// ---- core/sec_store.sv ----
// Byte store of the three security registers and the read-ahead FIFO.
// Assumes one clock; store contents are not reset (nonvolatile model).
`timescale 1ns/1ps
`default_nettype none
`include "flash_sec_cfg.svh"
module sec_store_mem #(
  parameter int unsigned ENTRIES = `SEC_ENTRIES
) (
  input wire logic clk_in,
  store_if.mem     s
);
  logic [7:0] mem [ENTRIES];
  logic [7:0] rd_r;
  // Programming only clears bits, as on erased flash cells
  always_ff @(posedge clk_in) begin
    if (s.wr_en) begin
      mem[s.wr_idx] <= s.wr_erase ? 8'hFF : (mem[s.wr_idx] & s.wr_data);
    end
    if (s.rd_en) begin
      rd_r <= mem[s.rd_idx];
    end
  end
  assign s.rd_data = rd_r;
endmodule

module sec_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = `FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  store_if.fifo    s
);
  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] buf_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   n_r, n_nxt;
  logic          push, pop;
  assign s.f_in_ready  = (n_r != (AW+1)'(DEPTH));
  assign s.f_out_valid = (n_r != '0);
  assign s.f_out_data  = buf_r[rp_r];
  assign push = s.f_in_valid & s.f_in_ready & ~s.f_flush;
  assign pop  = s.f_out_valid & s.f_out_ready & ~s.f_flush;
  always_comb begin
    wp_nxt = wp_r + AW'(push);
    rp_nxt = rp_r + AW'(pop);
    n_nxt  = n_r + (AW+1)'(push) - (AW+1)'(pop);
    if (s.f_flush) begin
      wp_nxt = '0;
      rp_nxt = '0;
      n_nxt  = '0;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_r <= '0;
      rp_r <= '0;
      n_r  <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      n_r  <= n_nxt;
    end
  end
  always_ff @(posedge clk_in) begin
    if (push) begin
      buf_r[wp_r] <= s.f_in_data[W-1:0];
    end
  end
endmodule
`default_nettype wire

// ---- core/flash_sec_engine.sv ----
// Security register access and quad read parameter engine of a flash.
// Assumes a host drives chip select, serial clock and data pins; status
// bits come from status register logic on the same clock.
// Operation
// - Security erase needs the write enable latch.
// - Bits 15..12 pick register 1..3; bits 11..8 and above zero.
// - Erase runs only if select rises on a byte boundary; code needs it right after the address, no extra clocks.
// - Erase is self-timed, busy high until done.
// - Finished security erase clears the write enable latch.
// - Set lock bit blocks erase and program of its register.
// - Program needs the latch; writes 1 to 256 bytes.
// - Read: command, address, eight dummy clocks, sampled on rises.
// - Read data on single line, on falls, MSB first.
// - Read byte address wraps last to first byte.
// - Four-byte mode takes 32-bit addresses, else 24-bit.
// - Security commands only in single-line serial mode.
// - Read parameter command only in quad command mode.
// - Dummy codes 0..3 give 2, 4, 6, 8 clocks.
// - Wrap codes 0..3 give 8, 16, 32, 64 bytes.
// - Reset gives 8-byte wrap, two dummy clocks.
// - Programmable dummy count only for quad fast reads.
// - Serial wrap length survives switch to quad.
// - Burst wrap read returns to window start.
// - Enter quad ignored while quad enable bit clear.
`timescale 1ns/1ps
`default_nettype none
`include "flash_sec_cfg.svh"
module flash_sec_engine #(
  parameter int unsigned ERASE_CYCLES = `SEC_ERASE_US * `CLK_MHZ,
  parameter int unsigned PROG_CYCLES  = `SEC_PROG_US * `CLK_MHZ,
  parameter int unsigned FIFO_DEPTH   = `FIFO_DEPTH
) (
  input  wire logic       CLK_IN,
  input  wire logic       RSTN_IN,
  input  wire logic       CS_N_IN,
  input  wire logic       SCLK_IN,
  input  wire logic [3:0] IO_IN,
  output logic      [3:0] IO_OUT,
  output logic      [3:0] IO_OE_OUT,
  input  wire logic       WRITE_ENABLE_LATCH_IN,
  input  wire logic [2:0] SECURITY_LOCK_BITS_IN,
  input  wire logic       QUAD_ENABLE_BIT_IN,
  input  wire logic       FOUR_BYTE_ADDR_IN,
  input  wire logic       SERIAL_WRAP_LOAD_IN,
  input  wire logic [1:0] SERIAL_WRAP_LENGTH_FIELD_IN,
  input  wire logic       RESET_INSTR_IN,
  input  wire logic [7:0] ARRAY_DATA_IN,
  output logic            ARRAY_RD_OUT,
  output logic     [31:0] ARRAY_ADDR_OUT,
  output logic            BUSY_OUT,
  output logic            WEL_CLEAR_OUT,
  output logic            QUAD_COMMAND_MODE_OUT,
  output logic      [3:0] DUMMY_CLOCKS_OUT,
  output logic      [6:0] WRAP_LENGTH_OUT
);
  store_if #(.DW(8)) s ();

  sec_store_mem #(.ENTRIES(`SEC_ENTRIES)) u_mem (
    .clk_in (CLK_IN),
    .s      (s)
  );

  sec_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in  (CLK_IN),
    .rstn_in (RSTN_IN),
    .s       (s)
  );

  // Pins pass two flops; bit 5 chip select, bit 4 clock, 3..0 data
  logic [5:0] s1_r, s2_r;
  logic       sclk_d_r, csn_d_r;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      s1_r     <= 6'h20;
      s2_r     <= 6'h20;
      sclk_d_r <= 1'b0;
      csn_d_r  <= 1'b1;
    end else begin
      s1_r     <= {CS_N_IN, SCLK_IN, IO_IN};
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[4];
      csn_d_r  <= s2_r[5];
    end
  end

  logic       rise, fall, cs_act, cs_end;
  logic [3:0] io;
  assign io     = s2_r[3:0];
  assign rise   = s2_r[4] & ~sclk_d_r;
  assign fall   = ~s2_r[4] & sclk_d_r;
  assign cs_act = ~s2_r[5];
  assign cs_end = s2_r[5] & ~csn_d_r;

  // Frame decoder
  flash_sec_pkg::frame_t st_r, st_nxt;
  logic [31:0] sr_r, sr_nxt, addr_r, addr_nxt, nsr;
  logic [5:0]  cnt_r, cnt_nxt, ncnt, abits, ndum;
  logic [7:0]  cmd_r, cmd_nxt, baddr_r, baddr_nxt;
  logic [1:0]  sel_r, sel_nxt, dsel_r, dsel_nxt, wsel_r, wsel_nxt;
  logic        vld_r, vld_nxt, ok_r, ok_nxt, pany_r, pany_nxt;
  logic        quad_r, quad_nxt, busy_r, busy_nxt, erase_r, erase_nxt;
  logic [15:0] bcnt_r, bcnt_nxt;
  logic [8:0]  eidx_r, eidx_nxt;
  logic        welclr_r, welclr_nxt, go_r, go_nxt;
  logic        wen_r, wen_nxt, wera_r, wera_nxt;
  logic [9:0]  widx_r, widx_nxt;
  logic [7:0]  wdat_r, wdat_nxt;
  logic        va, lk;
  logic [1:0]  ns;

  always_comb begin
    st_nxt = st_r;
    sr_nxt = sr_r;
    cnt_nxt = cnt_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    baddr_nxt = baddr_r;
    sel_nxt = sel_r;
    dsel_nxt = dsel_r;
    wsel_nxt = wsel_r;
    vld_nxt = vld_r;
    ok_nxt = ok_r;
    pany_nxt = pany_r;
    quad_nxt = quad_r;
    busy_nxt = busy_r;
    erase_nxt = erase_r;
    bcnt_nxt = bcnt_r;
    eidx_nxt = eidx_r;
    welclr_nxt = 1'b0;
    go_nxt = 1'b0;
    wen_nxt = 1'b0;
    wera_nxt = 1'b0;
    widx_nxt = widx_r;
    wdat_nxt = wdat_r;
    nsr = quad_r ? {sr_r[27:0], io} : {sr_r[30:0], io[0]};
    ncnt = cnt_r + (quad_r ? 6'h04 : 6'h01);
    abits = FOUR_BYTE_ADDR_IN ? `ADDR_BITS_4B : `ADDR_BITS_3B;
    ndum = (cmd_r == `OP_SEC_READ) ? `SEC_DUMMY_CLKS
                                   : {2'b00, DUMMY_CLOCKS_OUT};
    ns = nsr[13:12];
    va = (nsr[15:12] >= `SEC_SEL_FIRST) && (nsr[15:12] <= `SEC_SEL_LAST)
         && (nsr[11:8] == 4'h0) && (nsr[23:16] == 8'h00)
         && (!FOUR_BYTE_ADDR_IN || nsr[31:24] == 8'h00);
    lk = SECURITY_LOCK_BITS_IN[ns - 2'd1];
    // Erase walks all 256 bytes to FFh first
    if (busy_r) begin
      if (erase_r && !eidx_r[8]) begin
        wen_nxt = 1'b1;
        wera_nxt = 1'b1;
        widx_nxt = {sel_r, eidx_r[7:0]};
        eidx_nxt = eidx_r + 9'h001;
      end
      if (bcnt_r == 16'h0000) begin
        busy_nxt = 1'b0;
        welclr_nxt = 1'b1;
      end else begin
        bcnt_nxt = bcnt_r - 16'h0001;
      end
    end
    if (SERIAL_WRAP_LOAD_IN) begin
      wsel_nxt = SERIAL_WRAP_LENGTH_FIELD_IN;
    end
    if (RESET_INSTR_IN) begin
      dsel_nxt = `DUMMY_SEL_RST;
      wsel_nxt = `WRAP_SEL_RST;
      quad_nxt = 1'b0;
    end
    if (cs_end) begin
      if (st_r == flash_sec_pkg::ST_SKIP && cnt_r == 6'h00) begin
        if (cmd_r == `OP_SEC_ERASE && ok_r) begin
          busy_nxt = 1'b1;
          erase_nxt = 1'b1;
          eidx_nxt = 9'h000;
          bcnt_nxt = 16'(ERASE_CYCLES - 1);
        end
        if (cmd_r == `OP_ENTER_QUAD && QUAD_ENABLE_BIT_IN) begin
          quad_nxt = 1'b1;
        end
        if (cmd_r == `OP_EXIT_QUAD) begin
          quad_nxt = 1'b0;
        end
      end
      if (cmd_r == `OP_SEC_PROG && pany_r) begin
        busy_nxt = 1'b1;
        erase_nxt = 1'b0;
        bcnt_nxt = 16'(PROG_CYCLES - 1);
      end
      st_nxt = flash_sec_pkg::ST_CMD;
      cnt_nxt = 6'h00;
      cmd_nxt = `OP_NONE;
      ok_nxt = 1'b0;
      pany_nxt = 1'b0;
    end else if (cs_act && rise) begin
      sr_nxt = nsr;
      case (st_r)
        flash_sec_pkg::ST_CMD: begin
          if (ncnt == 6'h08) begin
            cnt_nxt = 6'h00;
            st_nxt = flash_sec_pkg::ST_SKIP;
            cmd_nxt = `OP_NONE;
            if (busy_r) begin
              cmd_nxt = `OP_NONE;
            end else if (!quad_r) begin
              if (nsr[7:0] inside {`OP_SEC_ERASE, `OP_SEC_PROG,
                                   `OP_SEC_READ}) begin
                cmd_nxt = nsr[7:0];
                st_nxt = flash_sec_pkg::ST_ADDR;
              end else if (nsr[7:0] == `OP_ENTER_QUAD) begin
                cmd_nxt = nsr[7:0];
              end
            end else begin
              if (nsr[7:0] inside {`OP_FAST_READ, `OP_QIO_READ,
                                   `OP_WRAP_READ}) begin
                cmd_nxt = nsr[7:0];
                st_nxt = flash_sec_pkg::ST_ADDR;
              end else if (nsr[7:0] == `OP_SET_PARAM) begin
                cmd_nxt = nsr[7:0];
                st_nxt = flash_sec_pkg::ST_WDATA;
              end else if (nsr[7:0] == `OP_EXIT_QUAD) begin
                cmd_nxt = nsr[7:0];
              end
            end
          end else begin
            cnt_nxt = ncnt;
          end
        end
        flash_sec_pkg::ST_ADDR: begin
          if (ncnt == abits) begin
            cnt_nxt = 6'h00;
            addr_nxt = nsr;
            vld_nxt = va;
            ok_nxt = va & ~lk & WRITE_ENABLE_LATCH_IN;
            sel_nxt = ns - 2'd1;
            baddr_nxt = nsr[7:0];
            if (cmd_r == `OP_SEC_ERASE) begin
              st_nxt = flash_sec_pkg::ST_SKIP;
            end else if (cmd_r == `OP_SEC_PROG) begin
              st_nxt = flash_sec_pkg::ST_WDATA;
            end else begin
              st_nxt = flash_sec_pkg::ST_DUMMY;
              go_nxt = 1'b1;
            end
          end else begin
            cnt_nxt = ncnt;
          end
        end
        flash_sec_pkg::ST_DUMMY: begin
          if (cnt_r + 6'h01 == ndum) begin
            cnt_nxt = 6'h00;
            st_nxt = flash_sec_pkg::ST_RDATA;
          end else begin
            cnt_nxt = cnt_r + 6'h01;
          end
        end
        flash_sec_pkg::ST_WDATA: begin
          if (ncnt == 6'h08) begin
            cnt_nxt = 6'h00;
            if (cmd_r == `OP_SET_PARAM) begin
              dsel_nxt = nsr[5:4];
              wsel_nxt = nsr[1:0];
            end else if (ok_r) begin
              // Each byte is stored as it arrives while select is low
              wen_nxt = 1'b1;
              widx_nxt = {sel_r, baddr_r};
              wdat_nxt = nsr[7:0];
              baddr_nxt = baddr_r + 8'h01;
              pany_nxt = 1'b1;
            end
          end else begin
            cnt_nxt = ncnt;
          end
        end
        flash_sec_pkg::ST_SKIP: begin
          if (cnt_r != 6'h3F) begin
            cnt_nxt = cnt_r + 6'h01;
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_r <= flash_sec_pkg::ST_CMD;
      sr_r <= 32'h0000_0000;
      cnt_r <= 6'h00;
      cmd_r <= `OP_NONE;
      addr_r <= 32'h0000_0000;
      baddr_r <= 8'h00;
      sel_r <= 2'h0;
      dsel_r <= `DUMMY_SEL_RST;
      wsel_r <= `WRAP_SEL_RST;
      vld_r <= 1'b0;
      ok_r <= 1'b0;
      pany_r <= 1'b0;
      quad_r <= 1'b0;
      busy_r <= 1'b0;
      erase_r <= 1'b0;
      bcnt_r <= 16'h0000;
      eidx_r <= 9'h100;
      welclr_r <= 1'b0;
      go_r <= 1'b0;
      wen_r <= 1'b0;
      wera_r <= 1'b0;
      widx_r <= 10'h000;
      wdat_r <= 8'hFF;
    end else begin
      st_r <= st_nxt;
      sr_r <= sr_nxt;
      cnt_r <= cnt_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      baddr_r <= baddr_nxt;
      sel_r <= sel_nxt;
      dsel_r <= dsel_nxt;
      wsel_r <= wsel_nxt;
      vld_r <= vld_nxt;
      ok_r <= ok_nxt;
      pany_r <= pany_nxt;
      quad_r <= quad_nxt;
      busy_r <= busy_nxt;
      erase_r <= erase_nxt;
      bcnt_r <= bcnt_nxt;
      eidx_r <= eidx_nxt;
      welclr_r <= welclr_nxt;
      go_r <= go_nxt;
      wen_r <= wen_nxt;
      wera_r <= wera_nxt;
      widx_r <= widx_nxt;
      wdat_r <= wdat_nxt;
    end
  end

  assign s.wr_en = wen_r;
  assign s.wr_erase = wera_r;
  assign s.wr_idx = widx_r;
  assign s.wr_data = wdat_r;
  assign BUSY_OUT = busy_r;
  assign WEL_CLEAR_OUT = welclr_r;
  assign QUAD_COMMAND_MODE_OUT = quad_r;
  assign DUMMY_CLOCKS_OUT = {1'b0, dsel_r, 1'b0} + `DUMMY_BASE;
  assign WRAP_LENGTH_OUT = `WRAP_BASE_LEN << wsel_r;

  // Read-ahead FIFO, one beat per clock fall
  logic        fon_r, fon_nxt, pend_r, pend_nxt;
  logic [31:0] fa_r, fa_nxt, nfa, wm;
  logic [7:0]  sh_r, sh_nxt, b;
  logic [2:0]  left_r, left_nxt;
  logic [3:0]  dout_r, dout_nxt, oe_r, oe_nxt;
  logic        issue, fsec, pop;

  always_comb begin
    fon_nxt = fon_r;
    pend_nxt = 1'b0;
    fa_nxt = fa_r;
    sh_nxt = sh_r;
    left_nxt = left_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    pop = 1'b0;
    b = 8'hFF;
    fsec = (cmd_r == `OP_SEC_READ);
    wm = {25'h0, WRAP_LENGTH_OUT - 7'h01};
    issue = fon_r & s.f_in_ready & ~pend_r;
    case (cmd_r)
      `OP_SEC_READ: nfa = {fa_r[31:8], fa_r[7:0] + 8'h01};
      `OP_WRAP_READ: nfa = (fa_r & ~wm) | ((fa_r + 32'h1) & wm);
      default: nfa = fa_r + 32'h1;
    endcase
    if (go_r) begin
      fon_nxt = 1'b1;
      fa_nxt = addr_r;
    end else if (issue) begin
      pend_nxt = 1'b1;
      fa_nxt = nfa;
    end
    if (cs_act && fall && st_r == flash_sec_pkg::ST_RDATA) begin
      if (left_r == 3'h0) begin
        // An underrun sends FFh rather than stalling the host clock
        pop = s.f_out_valid;
        b = s.f_out_valid ? s.f_out_data : 8'hFF;
        if (quad_r) begin
          dout_nxt = b[7:4];
          sh_nxt = {b[3:0], 4'h0};
          left_nxt = 3'h1;
          oe_nxt = 4'hF;
        end else begin
          dout_nxt = {2'b00, b[7], 1'b0};
          sh_nxt = {b[6:0], 1'b0};
          left_nxt = 3'h7;
          oe_nxt = 4'h2;
        end
      end else begin
        dout_nxt = quad_r ? sh_r[7:4] : {2'b00, sh_r[7], 1'b0};
        sh_nxt = quad_r ? {sh_r[3:0], 4'h0} : {sh_r[6:0], 1'b0};
        left_nxt = left_r - 3'h1;
      end
    end
    if (cs_end) begin
      fon_nxt = 1'b0;
      pend_nxt = 1'b0;
      left_nxt = 3'h0;
      oe_nxt = 4'h0;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      fon_r <= 1'b0;
      pend_r <= 1'b0;
      fa_r <= 32'h0000_0000;
      sh_r <= 8'hFF;
      left_r <= 3'h0;
      dout_r <= 4'h0;
      oe_r <= 4'h0;
    end else begin
      fon_r <= fon_nxt;
      pend_r <= pend_nxt;
      fa_r <= fa_nxt;
      sh_r <= sh_nxt;
      left_r <= left_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign s.rd_en = issue & fsec;
  assign s.rd_idx = {sel_r, fa_r[7:0]};
  assign s.f_flush = cs_end | go_r;
  assign s.f_in_valid = pend_r;
  assign s.f_in_data = fsec ? (vld_r ? s.rd_data : 8'hFF)
                            : ARRAY_DATA_IN;
  assign s.f_out_ready = pop;
  assign ARRAY_RD_OUT = issue & ~fsec;
  assign ARRAY_ADDR_OUT = fa_r;
  assign IO_OUT = dout_r;
  assign IO_OE_OUT = oe_r;
endmodule
`default_nettype wire

// ---- bench/flash_sec_engine_chk.sv ----
// Checker of the security register and read parameter engine.
// Sees only the engine's top ports; bound to it at the foot of the file.
`timescale 1ns/1ps
`default_nettype none
module flash_sec_engine_chk #(
  parameter int unsigned ERASE_CYCLES = 4000,
  parameter int unsigned PROG_CYCLES  = 800
) (
  input wire logic       CLK_IN,
  input wire logic       RSTN_IN,
  input wire logic       CS_N_IN,
  input wire logic       WRITE_ENABLE_LATCH_IN,
  input wire logic       QUAD_ENABLE_BIT_IN,
  input wire logic       RESET_INSTR_IN,
  input wire logic       BUSY_OUT,
  input wire logic       WEL_CLEAR_OUT,
  input wire logic       QUAD_COMMAND_MODE_OUT,
  input wire logic [3:0] DUMMY_CLOCKS_OUT,
  input wire logic [6:0] WRAP_LENGTH_OUT
);
  logic [31:0] busy_len_r;
  logic [31:0] busy_len_nxt;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  always_comb busy_len_nxt = BUSY_OUT ? busy_len_r + 32'h1 : 32'h0;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) busy_len_r <= 32'h0;
    else busy_len_r <= busy_len_nxt;
  end
  sequence s_hold; BUSY_OUT [*8]; endsequence
  sequence s_clr; ##[0:1] WEL_CLEAR_OUT ##1 !WEL_CLEAR_OUT; endsequence
  property p_wel; $rose(BUSY_OUT) |-> WRITE_ENABLE_LATCH_IN; endproperty
  a_wel: assert property (p_wel)
    else $error("busy without write enable");
  property p_cs; $rose(BUSY_OUT) |-> CS_N_IN; endproperty
  a_cs: assert property (p_cs)
    else $error("busy inside a frame");
  property p_serial; $rose(BUSY_OUT) |-> !QUAD_COMMAND_MODE_OUT; endproperty
  a_serial: assert property (p_serial)
    else $error("busy started in quad mode");
  property p_hold; $rose(BUSY_OUT) |=> s_hold; endproperty
  a_hold: assert property (p_hold)
    else $error("busy too short");
  property p_max; BUSY_OUT |-> busy_len_r < ERASE_CYCLES + 1; endproperty
  a_max: assert property (p_max)
    else $error("busy too long");
  property p_clr; $fell(BUSY_OUT) |-> s_clr; endproperty
  a_clr: assert property (p_clr)
    else $error("no single latch clear at busy end");
  property p_qe; $rose(QUAD_COMMAND_MODE_OUT) |-> QUAD_ENABLE_BIT_IN; endproperty
  a_qe: assert property (p_qe)
    else $error("quad mode without enable bit");
  property p_wrap;
    $rose(QUAD_COMMAND_MODE_OUT) |-> $stable(WRAP_LENGTH_OUT);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap length lost on quad entry");
  property p_dflt;
    RESET_INSTR_IN |-> ##[1:2] (DUMMY_CLOCKS_OUT == 4'h2 &&
      WRAP_LENGTH_OUT == 7'h08 && !QUAD_COMMAND_MODE_OUT);
  endproperty
  a_dflt: assert property (p_dflt)
    else $error("defaults not restored");
  property p_fixed;
    !QUAD_COMMAND_MODE_OUT && !RESET_INSTR_IN && !$past(RESET_INSTR_IN)
      |=> $stable(DUMMY_CLOCKS_OUT);
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("dummy count changed in serial mode");
  property p_codes;
    DUMMY_CLOCKS_OUT inside {4'h2, 4'h4, 4'h6, 4'h8} &&
      WRAP_LENGTH_OUT inside {7'h08, 7'h10, 7'h20, 7'h40};
  endproperty
  a_codes: assert property (p_codes)
    else $error("read parameter out of range");
endmodule
bind flash_sec_engine flash_sec_engine_chk #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES (PROG_CYCLES)
) flash_sec_engine_chk_inst (.*);
`default_nettype wire

// ---- bench/host_model.sv ----
// Host flash controller model driving chip select, clock and data pins.
// Assumes calls at falling edges of the bench clock; SPI mode 0.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] io_in,
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic      [3:0] io_out,
  output logic      [3:0] oe_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    io_out = 4'h0;
    oe_out = 4'h0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic start();
    cs_n_out = 1'b0;
    idle(4);
  endtask
  // Samples before each rise, after the fall's data settled
  task automatic shift(input int n, input bit q, input bit rel,
                       input logic [63:0] tx, output logic [63:0] rx);
    rx = 64'h0;
    oe_out = rel ? 4'h0 : (q ? 4'hF : 4'h1);
    for (int k = n - 1; k >= 0; k--) begin
      io_out = q ? tx[k*4 +: 4] : {3'h0, tx[k]};
      idle(4);
      rx = q ? {rx[59:0], io_in} : {rx[62:0], io_in[1]};
      sclk_out = 1'b1;
      idle(4);
      sclk_out = 1'b0;
    end
  endtask
  // Chip select rises with the clock low, after however many bits the caller shifted
  task automatic stop();
    idle(4);
    cs_n_out = 1'b1;
    oe_out = 4'h0;
    idle(8);
  endtask
endmodule
`default_nettype wire

// ---- bench/flash_sec_engine_tb_top.sv ----
// Self-checking bench of the security register and read parameter engine.
// Assumes the checker and host model are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
module flash_sec_engine_tb_top;
  localparam int unsigned EC = 300;
  localparam int unsigned PC = 20;
  logic        CLK_IN, RSTN_IN, CS_N_IN, SCLK_IN, WRITE_ENABLE_LATCH_IN;
  logic        QUAD_ENABLE_BIT_IN, FOUR_BYTE_ADDR_IN, SERIAL_WRAP_LOAD_IN;
  logic        RESET_INSTR_IN, ARRAY_RD_OUT, BUSY_OUT, WEL_CLEAR_OUT;
  logic        QUAD_COMMAND_MODE_OUT;
  logic [1:0]  SERIAL_WRAP_LENGTH_FIELD_IN;
  logic [2:0]  SECURITY_LOCK_BITS_IN;
  logic [3:0]  IO_IN, IO_OUT, IO_OE_OUT, DUMMY_CLOCKS_OUT, h_io, h_oe;
  logic [6:0]  WRAP_LENGTH_OUT;
  logic [7:0]  ARRAY_DATA_IN;
  logic [31:0] ARRAY_ADDR_OUT, busy_cyc, wel_clrs, b0, c0;
  logic [63:0] rx;
  int          fails, num_checks;
  flash_sec_engine #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC))
    flash_sec_engine_inst (.*);
  host_model host_model_inst (.clk_in(CLK_IN), .io_in(IO_IN),
    .cs_n_out(CS_N_IN), .sclk_out(SCLK_IN), .io_out(h_io), .oe_out(h_oe));
  // A line nobody drives shows the inverse of its last host value
  assign IO_IN = (IO_OE_OUT & IO_OUT) | (~IO_OE_OUT & (h_io ^ ~h_oe));
  initial begin
    CLK_IN = 1'b0;
    forever #12.5 CLK_IN = ~CLK_IN;
  end
  always @(posedge CLK_IN) begin
    if (ARRAY_RD_OUT) ARRAY_DATA_IN <= ARRAY_ADDR_OUT[7:0] ^ 8'h5A;
    if (BUSY_OUT) busy_cyc <= busy_cyc + 32'h1;
    if (WEL_CLEAR_OUT) wel_clrs <= wel_clrs + 32'h1;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tx(input int n, input bit q, input logic [63:0] v);
    host_model_inst.shift(n, q, 1'b0, v, rx);
  endtask
  task automatic frame(input logic [7:0] op, input bit q, input int n,
                       input logic [63:0] a);
    b0 = busy_cyc;
    c0 = wel_clrs;
    host_model_inst.start();
    tx(q ? 2 : 8, q, {56'h0, op});
    if (n > 0) tx(n, q, a);
  endtask
  task automatic cmd(input logic [7:0] op, input bit q, input int n,
                     input logic [63:0] a);
    frame(op, q, n, a);
    host_model_inst.stop();
  endtask
  task automatic sec_op(input logic [7:0] op, input bit write_enable_latch,
                        input logic [63:0] a, input int n, input logic [63:0] d);
    WRITE_ENABLE_LATCH_IN = write_enable_latch;
    frame(op, 1'b0, 24, a);
    if (n > 0) tx(n, 1'b0, d);
    host_model_inst.stop();
  endtask
  // Status logic drops the latch after the clear pulse
  task automatic done_busy(input bit busy, input int unsigned len);
    int n;
    n = 0;
    while (BUSY_OUT === 1'b1 && n < 5000) begin
      @(negedge CLK_IN);
      n++;
    end
    repeat (2) @(negedge CLK_IN);
    check({busy_cyc - b0, wel_clrs - c0}, {busy ? len : 32'h0, 31'h0, busy});
    WRITE_ENABLE_LATCH_IN = 1'b0;
  endtask
  task automatic rd_sec(input logic [63:0] a, input int n);
    frame(8'h48, 1'b0, n, a);
    tx(8, 1'b0, 64'h0);
    host_model_inst.shift(32, 1'b0, 1'b0, 64'h0, rx);
    host_model_inst.stop();
  endtask
  task automatic t_erase();
    sec_op(8'h44, 1, 64'h001000, 1, 0); done_busy(0, EC);
    sec_op(8'h44, 0, 64'h0010A5, 0, 0); done_busy(0, EC);
    sec_op(8'h44, 1, 64'h001100, 0, 0); done_busy(0, EC);
    sec_op(8'h44, 1, 64'h004000, 0, 0); done_busy(0, EC);
    SECURITY_LOCK_BITS_IN = 3'h1;
    sec_op(8'h44, 1, 64'h001000, 0, 0); done_busy(0, EC);
    SECURITY_LOCK_BITS_IN = 3'h0;
    sec_op(8'h44, 1, 64'h0010A5, 0, 0); done_busy(1, EC);
    sec_op(8'h44, 1, 64'h002000, 0, 0); done_busy(1, EC);
  endtask
  task automatic t_prog();
    sec_op(8'h42, 1, 64'h0010FE, 24, 64'hA53C5A); done_busy(1, PC);
    rd_sec(64'h0010FE, 24); check(rx, 64'hA53C5AFF);
    FOUR_BYTE_ADDR_IN = 1'b1;
    rd_sec(64'h000010FF, 32); check(rx, 64'h3C5AFFFF);
    FOUR_BYTE_ADDR_IN = 1'b0;
    SECURITY_LOCK_BITS_IN = 3'h2;
    sec_op(8'h42, 1, 64'h002000, 8, 0); done_busy(0, PC);
    SECURITY_LOCK_BITS_IN = 3'h0;
    rd_sec(64'h002000, 24); check(rx, 64'hFFFFFFFF);
  endtask
  task automatic t_params();
    cmd(8'hC0, 0, 8, 64'h33); check(DUMMY_CLOCKS_OUT, 4'h2);
    SERIAL_WRAP_LENGTH_FIELD_IN = 2'h2;
    SERIAL_WRAP_LOAD_IN = 1'b1;
    @(negedge CLK_IN);
    SERIAL_WRAP_LOAD_IN = 1'b0;
    cmd(8'h38, 0, 0, 0); check(QUAD_COMMAND_MODE_OUT, 1'b0);
    QUAD_ENABLE_BIT_IN = 1'b1;
    cmd(8'h38, 0, 0, 0);
    check({QUAD_COMMAND_MODE_OUT, WRAP_LENGTH_OUT}, {1'b1, 7'h20});
    WRITE_ENABLE_LATCH_IN = 1'b1;
    cmd(8'h44, 1, 6, 64'h001000); done_busy(0, EC);
    for (int c = 0; c < 4; c++) begin
      cmd(8'hC0, 1, 2, {58'h0, 2'(c), 2'h0, 2'(c)});
      check({DUMMY_CLOCKS_OUT, WRAP_LENGTH_OUT},
            {4'(2 + 2 * c), 7'(8 << c)});
    end
    RESET_INSTR_IN = 1'b1;
    @(negedge CLK_IN);
    RESET_INSTR_IN = 1'b0;
    repeat (2) @(negedge CLK_IN);
    check({QUAD_COMMAND_MODE_OUT, DUMMY_CLOCKS_OUT, WRAP_LENGTH_OUT},
          {1'b0, 4'h2, 7'h08});
  endtask
  task automatic t_wrap();
    cmd(8'h38, 0, 0, 0);
    cmd(8'hC0, 1, 2, 64'h00);
    frame(8'h0C, 1, 6, 64'h000004);
    host_model_inst.shift(2, 1'b1, 1'b1, 64'h0, rx);
    host_model_inst.shift(16, 1'b1, 1'b1, 64'h0, rx);
    host_model_inst.stop();
    check(rx, 64'h5E5F5C5D5A5B5859);
  endtask
  initial begin
    {RSTN_IN, WRITE_ENABLE_LATCH_IN, QUAD_ENABLE_BIT_IN} = 3'h0;
    {FOUR_BYTE_ADDR_IN, SERIAL_WRAP_LOAD_IN, RESET_INSTR_IN} = 3'h0;
    SECURITY_LOCK_BITS_IN = 3'h0;
    SERIAL_WRAP_LENGTH_FIELD_IN = 2'h0;
    ARRAY_DATA_IN = 8'h00;
    busy_cyc = 32'h0;
    wel_clrs = 32'h0;
    repeat (10) @(negedge CLK_IN);
    RSTN_IN = 1'b1;
    repeat (4) @(negedge CLK_IN);
    check({QUAD_COMMAND_MODE_OUT, DUMMY_CLOCKS_OUT, WRAP_LENGTH_OUT},
          {1'b0, 4'h2, 7'h08});
    t_erase();
    t_prog();
    t_params();
    t_wrap();
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge CLK_IN);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
